// ---- shared/cdb_consts.svh ----
// Constants for the cache, DRAM and expansion-bus configuration bank.
// Assumes inclusion by the package and by every design file of the bank.
`ifndef CDB_CONSTS_SVH
`define CDB_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define CDB_IDX_L2CTL        6'h18
`define CDB_IDX_REFSETUP     6'h19
`define CDB_IDX_STBSETUP     6'h1a
`define CDB_IDX_BANKSPEED    6'h1b
`define CDB_IDX_STATUS       6'h1c

// Writable bit masks; reserved and read-only bits are zero here.
`define CDB_MASK_L2CTL       8'hf3
`define CDB_MASK_REFSETUP    8'hf7
`define CDB_MASK_STBSETUP    8'hdb
`define CDB_MASK_BANKSPEED   8'h1f

// Reset values; bit 7 of the strobe setup register comes from the strap.
`define CDB_RST_L2CTL        8'h00
`define CDB_RST_REFSETUP     8'h00
`define CDB_RST_STBSETUP     8'h00
`define CDB_RST_BANKSPEED    8'h00

// Field positions.
`define CDB_L2_BURST_FAST    7
`define CDB_L2_BUS_WAIT      6
`define CDB_L2_OFF_WAIT      5
`define CDB_L2_WRITE_WAIT    4
`define CDB_L2_HIDDEN_REF    1
`define CDB_L2_STD_REF_OFF   0
`define CDB_STB_START_DELAY  7
`define CDB_STB_CPU_CACHE_OFF 6
`define CDB_STB_FORCE_HIT    4
`define CDB_STB_FORCE_EN     3
`define CDB_STB_DMA_LONG     1
`define CDB_STB_DMA_FAST     0
`define CDB_BS_LOCAL_BUS     4
`define CDB_BS_SPEED         0
`define CDB_ST_TURBO_PIN     3

// Timing counts in clocks.
`define CDB_RAS_ACT_MAX      3'd5
`define CDB_RAS_PRE_MAX      3'd4

// Bus responses.
`define CDB_RESP_OKAY        2'b00
`define CDB_RESP_SLVERR      2'b10

`endif

// ---- shared/cdb_pkg.sv ----
// Types shared by the configuration bank, its bus slave and its refresh sequencer.
// Assumes the constants header sits beside it.
`include "cdb_consts.svh"
package cdb_pkg;
    typedef enum logic [1:0] {REF_IDLE, REF_ACTIVE, REF_PRECH} cdb_ref_state_t;

    typedef struct packed {
        cdb_ref_state_t state;
        logic [2:0]     actLeft;
        logic [2:0]     preLeft;
        logic [1:0]     actCode;
        logic [1:0]     preCode;
        logic [2:0]     burstLeft;
    } cdb_ref_st_t;

    typedef struct packed {
        logic        awHeld;
        logic [7:0]  awAddr;
        logic        wHeld;
        logic [7:0]  wData;
        logic        wStrb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cdb_axi_st_t;

    typedef struct packed {
        logic [7:0] l2Ctl;
        logic [7:0] refSetup;
        logic [7:0] stbSetup;
        logic [7:0] bankSpeed;
        logic [2:0] dmaLine;
        logic       refPending;
        logic       busRefresh;
    } cdb_top_st_t;
endpackage

// ---- hw/cdb_axil_slave.sv ----
// AXI4-Lite slave front end: one write and one read under way at a time.
// Assumes the owner decodes the word index and returns hit and read data at once.
`timescale 1ns/1ps
`include "cdb_consts.svh"
module cdb_axil_slave
    import cdb_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Bus.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Register side.
    output logic             wrGo,
    output logic [5:0]       wrIdx,
    output logic [7:0]       wrData,
    output logic             wrLane0,
    input  wire logic        wrHit,
    output logic [5:0]       rdIdx,
    input  wire logic [7:0]  rdData,
    input  wire logic        rdHit
);
    cdb_axi_st_t st;
    cdb_axi_st_t next_st;

    // Address and data are held until both are present; the response blocks new ones.
    assign s_axi_awready = !st.awHeld && !st.bvalid;
    assign s_axi_wready  = !st.wHeld && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign wrGo          = st.awHeld && st.wHeld;
    assign wrIdx         = st.awAddr[7:2];
    assign wrData        = st.wData;
    assign wrLane0       = st.wStrb0;
    assign rdIdx         = s_axi_araddr[7:2];
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    // Next state of both channels.
    always_comb
    begin
        next_st = st;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.wHeld  = 1'b1;
            next_st.wData  = s_axi_wdata[7:0];
            next_st.wStrb0 = s_axi_wstrb[0];
        end
        if (wrGo)
        begin
            next_st.awHeld = 1'b0;
            next_st.wHeld  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = wrHit ? `CDB_RESP_OKAY : `CDB_RESP_SLVERR;
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = {24'h00_0000, rdHit ? rdData : 8'h00};
            next_st.rresp  = rdHit ? `CDB_RESP_OKAY : `CDB_RESP_SLVERR;
        end
        else if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (srst)
            next_st = '0;
    end

    // State register.
    always_ff @(posedge clk_sys)
    begin
        st <= next_st;
    end
endmodule

// ---- hw/cdb_refresh_seq.sv ----
// Burst refresh sequencer: row strobe active and precharge phases, repeated per burst.
// Assumes a start pulse only while idle; codes are latched at the start.
`timescale 1ns/1ps
`include "cdb_consts.svh"
module cdb_refresh_seq
    import cdb_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Control.
    input  wire logic       start,
    input  wire logic [1:0] actCode,
    input  wire logic [1:0] preCode,
    input  wire logic [2:0] countCode,
    // Status.
    output logic            busy,
    output logic            refStrobe
);
    cdb_ref_st_t st;
    cdb_ref_st_t next_st;

    assign busy      = st.state != REF_IDLE;
    assign refStrobe = st.state == REF_ACTIVE;

    // Phase counters count down the clocks left in the current phase.
    always_comb
    begin
        next_st = st;
        case (st.state)
            REF_IDLE:
                if (start)
                begin
                    next_st.state     = REF_ACTIVE;
                    next_st.actCode   = actCode;
                    next_st.preCode   = preCode;
                    next_st.burstLeft = countCode; // see (RQ9)
                    next_st.actLeft   = `CDB_RAS_ACT_MAX - 3'd1 - {1'b0, actCode}; // see (RQ7)
                end
            REF_ACTIVE:
                if (st.actLeft == 3'd0)
                begin
                    next_st.state   = REF_PRECH;
                    next_st.preLeft = `CDB_RAS_PRE_MAX - 3'd1 - {1'b0, st.preCode}; // see (RQ8)
                end
                else
                    next_st.actLeft = st.actLeft - 3'd1;
            REF_PRECH:
                if (st.preLeft != 3'd0)
                    next_st.preLeft = st.preLeft - 3'd1;
                else if (st.burstLeft == 3'd0)
                    next_st.state = REF_IDLE;
                else
                begin
                    next_st.state     = REF_ACTIVE;
                    next_st.burstLeft = st.burstLeft - 3'd1; // see (RQ9)
                    next_st.actLeft   = `CDB_RAS_ACT_MAX - 3'd1 - {1'b0, st.actCode};
                end
            default:
                next_st.state = REF_IDLE;
        endcase
        if (srst)
            next_st = '0;
    end

    // State register.
    always_ff @(posedge clk_sys)
    begin
        st <= next_st;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // Active width for the slowest code, and the shortest width of all.
    property p_refActLong;
        $rose(refStrobe) && st.actCode == 2'b00 |-> refStrobe [*5] ##1 !refStrobe;
    endproperty
    a_refActLong: assert property (p_refActLong) else $error("row strobe width not 5"); // see (RQ7)
    property p_refActShort;
        $rose(refStrobe) && st.actCode == 2'b11 |-> refStrobe [*2] ##1 !refStrobe;
    endproperty
    a_refActShort: assert property (p_refActShort) else $error("row strobe width not 2"); // see (RQ7)
    property p_refPre;
        $fell(refStrobe) && st.preCode == 2'b00 |-> !refStrobe [*4];
    endproperty
    a_refPre: assert property (p_refPre) else $error("precharge shorter than 4"); // see (RQ8)
    property p_refCount;
        st.state == REF_IDLE && start |=> st.burstLeft == $past(countCode);
    endproperty
    a_refCount: assert property (p_refCount) else $error("burst count not latched"); // see (RQ9)
    c_refBurst8: cover property (st.state == REF_IDLE && start && countCode == 3'b111);
endmodule

// ---- hw/cdb_config_regs.sv ----
// Cache, DRAM and expansion-bus configuration bank with its status register.
// Assumes an AXI4-Lite master on the system clock and pins synchronous to it.
// Function
// (RQ1) Control bit 7 set selects the fast X-2-2-2 cache read burst pattern.
// (RQ2) Control bit 6 set adds one wait state to every expansion-bus cycle.
// (RQ3) Control bit 5 set adds one wait state to DRAM and bus off cycles.
// (RQ4) Control bit 4: cache write wait in write-back, posted-write wait in write-through.
// (RQ5) Control bit 1 set hides burst refresh behind other activity.
// (RQ6) Control bit 0 set stops standard expansion-bus refresh cycles.
// (RQ7) Refresh row strobe width from setup bits 7-6: five, four, three, two clocks.
// (RQ8) Refresh precharge width from setup bits 5-4: four, three, two, one clocks.
// (RQ9) Refresh cycles per burst equal setup bits 2-0 plus one.
// (RQ10) Strobe setup bit 7 delays cycle-start strobe; reset value follows processor strap.
// (RQ11) Strobe setup bit 6 set disables the processor's on-chip cache.
// (RQ12) Setup bits 4-3: bit 3 clear normal, 11 forces hit, 01 forces miss.
// (RQ13) Setup bit 1 makes the DMA delay line three cycles, else two.
// (RQ14) Setup bit 0 selects fast DMA on processor clock, else bus clock.
// (RQ15) Bank bits 3, 2, 1 each disable their own row strobe output.
// (RQ16) Turbo speed when turbo pin status and software speed bit differ.
// (RQ17) Status bit 3 shows the live turbo pin level.
// (RQ18) Status bits 2-0 return a fixed chip version code.
// (RQ19) Bank bit 4 set enables local bus cycle support; cleared at reset.
// (RQ20) Read-only and reserved bits ignore writes; others take reset values.
`timescale 1ns/1ps
`include "cdb_consts.svh"
module cdb_config_regs
    import cdb_pkg::*;
#(
    parameter logic [2:0] VERSION_ID = 3'h5 // Arbitrary value.
)
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Register bus.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // System inputs.
    input  wire logic        cpuNewGen,
    input  wire logic        l2WriteBack,
    input  wire logic        turboPin,
    input  wire logic        refreshRequest,
    input  wire logic        dmaReqIn,
    input  wire logic [3:0]  rowStrobeReq,
    // Cache controls.
    output logic             cacheBurstFast,
    output logic             cacheWriteWait,
    output logic             postedWriteWait,
    output logic             forceHit,
    output logic             forceMiss,
    output logic             cpuCacheDisable,
    output logic             cycleStartDelay,
    // Bus and DRAM controls.
    output logic             busExtraWait,
    output logic             offCycleWait,
    output logic             busRefreshPulse,
    output logic             refreshBusy,
    output logic             refreshHoldCpu,
    output logic [3:0]       rowStrobe,
    output logic             localBusEnable,
    output logic             turboSpeed,
    // DMA controls.
    output logic             dmaReqDelayed,
    output logic             dmaClkFromCpu
);
    cdb_top_st_t st;
    cdb_top_st_t next_st;
    logic        wrGo;
    logic [5:0]  wrIdx;
    logic [7:0]  wrData;
    logic        wrLane0;
    logic        wrHit;
    logic [5:0]  rdIdx;
    logic [7:0]  rdData;
    logic        rdHit;
    logic        refStart;
    logic        refStrobe;
    logic [7:0]  statusValue;

    // Bus front end; it answers two cycles after both write halves are taken, one cycle after the read address.
    cdb_axil_slave u_slave (
        .clk_sys       (clk_sys),
        .srst          (srst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wrGo          (wrGo),
        .wrIdx         (wrIdx),
        .wrData        (wrData),
        .wrLane0       (wrLane0),
        .wrHit         (wrHit),
        .rdIdx         (rdIdx),
        .rdData        (rdData),
        .rdHit         (rdHit)
    );

    // Burst refresh engine; codes are latched when a burst starts.
    cdb_refresh_seq u_refresh (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .start     (refStart),
        .actCode   (st.refSetup[7:6]),
        .preCode   (st.refSetup[5:4]),
        .countCode (st.refSetup[2:0]),
        .busy      (refreshBusy),
        .refStrobe (refStrobe)
    );

    // Status is never stored, so the pin level is seen without delay.
    assign statusValue = {4'h0, turboPin, VERSION_ID}; // see (RQ17) see (RQ18)

    // Write decode; the status register is mapped but takes nothing.
    assign wrHit = (wrIdx >= `CDB_IDX_L2CTL) && (wrIdx <= `CDB_IDX_STATUS);

    // Read decode; reserved bits read zero because they are never stored.
    always_comb
    begin
        rdHit  = 1'b1;
        rdData = 8'h00;
        case (rdIdx)
            `CDB_IDX_L2CTL:     rdData = st.l2Ctl;
            `CDB_IDX_REFSETUP:  rdData = st.refSetup;
            `CDB_IDX_STBSETUP:  rdData = st.stbSetup;
            `CDB_IDX_BANKSPEED: rdData = st.bankSpeed;
            `CDB_IDX_STATUS:    rdData = statusValue;
            default:            rdHit  = 1'b0;
        endcase
    end

    // A pending request starts a burst as soon as the engine is idle.
    assign refStart = st.refPending && !refreshBusy;

    // Register state; the strap is caught while reset is held, so it follows the part.
    always_comb
    begin
        next_st            = st;
        next_st.busRefresh = refreshRequest && !st.l2Ctl[`CDB_L2_STD_REF_OFF]; // see (RQ6)
        next_st.dmaLine    = {st.dmaLine[1:0], dmaReqIn};
        // A new request in the start cycle stays pending, so none is lost.
        if (refStart)
            next_st.refPending = 1'b0;
        if (refreshRequest)
            next_st.refPending = 1'b1;
        if (wrGo && wrLane0)
        begin
            // Only writable bits change; the rest keep their values.
            case (wrIdx)
                `CDB_IDX_L2CTL:
                    next_st.l2Ctl = wrData & `CDB_MASK_L2CTL; // see (RQ20)
                `CDB_IDX_REFSETUP:
                    next_st.refSetup = wrData & `CDB_MASK_REFSETUP; // see (RQ20)
                `CDB_IDX_STBSETUP:
                    next_st.stbSetup = wrData & `CDB_MASK_STBSETUP; // see (RQ20)
                `CDB_IDX_BANKSPEED:
                    next_st.bankSpeed = wrData & `CDB_MASK_BANKSPEED; // see (RQ20)
                default:
                    next_st.l2Ctl = st.l2Ctl;
            endcase
        end
        if (srst)
        begin
            next_st           = '0;
            next_st.l2Ctl     = `CDB_RST_L2CTL;
            next_st.refSetup  = `CDB_RST_REFSETUP;
            next_st.stbSetup  = `CDB_RST_STBSETUP;
            next_st.bankSpeed = `CDB_RST_BANKSPEED; // see (RQ19) see (RQ20)
            next_st.stbSetup[`CDB_STB_START_DELAY] = cpuNewGen; // see (RQ10)
        end
    end

    // State register.
    always_ff @(posedge clk_sys)
    begin
        st <= next_st;
    end

    // Cache controls.
    assign cacheBurstFast  = st.l2Ctl[`CDB_L2_BURST_FAST]; // see (RQ1)
    assign cacheWriteWait  = st.l2Ctl[`CDB_L2_WRITE_WAIT] && l2WriteBack; // see (RQ4)
    assign postedWriteWait = st.l2Ctl[`CDB_L2_WRITE_WAIT] && !l2WriteBack; // see (RQ4)
    assign forceHit        = st.stbSetup[`CDB_STB_FORCE_EN]
                             && st.stbSetup[`CDB_STB_FORCE_HIT]; // see (RQ12)
    assign forceMiss       = st.stbSetup[`CDB_STB_FORCE_EN]
                             && !st.stbSetup[`CDB_STB_FORCE_HIT]; // see (RQ12)
    assign cpuCacheDisable = st.stbSetup[`CDB_STB_CPU_CACHE_OFF]; // see (RQ11)
    assign cycleStartDelay = st.stbSetup[`CDB_STB_START_DELAY]; // see (RQ10)

    // Bus and DRAM controls.
    assign busExtraWait    = st.l2Ctl[`CDB_L2_BUS_WAIT]; // see (RQ2)
    assign offCycleWait    = st.l2Ctl[`CDB_L2_OFF_WAIT]; // see (RQ3)
    assign busRefreshPulse = st.busRefresh; // see (RQ6)
    // Without hiding, the processor is held off for the whole burst.
    assign refreshHoldCpu  = refreshBusy && !st.l2Ctl[`CDB_L2_HIDDEN_REF]; // see (RQ5)
    assign localBusEnable  = st.bankSpeed[`CDB_BS_LOCAL_BUS]; // see (RQ19)
    assign turboSpeed      = turboPin ^ st.bankSpeed[`CDB_BS_SPEED]; // see (RQ16)

    // Row strobes: bank 0 has no disable bit, banks 1 to 3 are gated by theirs.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_bank
            if (gi == 0)
            begin : g_always
                assign rowStrobe[gi] = rowStrobeReq[gi] || refStrobe;
            end
            else
            begin : g_gated
                assign rowStrobe[gi] = (rowStrobeReq[gi] || refStrobe)
                                       && !st.bankSpeed[gi]; // see (RQ15)
            end
        end
    endgenerate

    // DMA delay line taps the shift chain at two or three clocks.
    assign dmaReqDelayed = st.stbSetup[`CDB_STB_DMA_LONG] ? st.dmaLine[2]
                                                          : st.dmaLine[1]; // see (RQ13)
    assign dmaClkFromCpu = st.stbSetup[`CDB_STB_DMA_FAST]; // see (RQ14)

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // A write to the control register lands one clock later with reserved bits clear.
    property p_wrReserved;
        wrGo && wrLane0 && wrIdx == `CDB_IDX_L2CTL |=> st.l2Ctl[3:2] == 2'b00;
    endproperty
    a_wrReserved: assert property (p_wrReserved) else $error("reserved bits took a write"); // see (RQ20)
    property p_busWait;
        wrGo && wrLane0 && wrIdx == `CDB_IDX_L2CTL |=> busExtraWait == $past(wrData[6]);
    endproperty
    a_busWait: assert property (p_busWait) else $error("bus wait not taken from write"); // see (RQ2)
    property p_offWait;
        wrGo && wrLane0 && wrIdx == `CDB_IDX_L2CTL |=> offCycleWait == $past(wrData[5]);
    endproperty
    a_offWait: assert property (p_offWait) else $error("off-cycle wait not from write"); // see (RQ3)
    property p_dmaShort;
        $rose(dmaReqIn) && !st.stbSetup[1] ##1 !st.stbSetup[1] ##1 !st.stbSetup[1]
            |-> dmaReqDelayed;
    endproperty
    a_dmaShort: assert property (p_dmaShort) else $error("short DMA delay wrong"); // see (RQ13)
    property p_dmaLong;
        !dmaReqIn ##1 dmaReqIn && st.stbSetup[1] ##1 st.stbSetup[1] ##1 st.stbSetup[1]
            |-> !dmaReqDelayed ##1 dmaReqDelayed;
    endproperty
    a_dmaLong: assert property (p_dmaLong) else $error("long DMA delay wrong"); // see (RQ13)
    property p_bankOff;
        st.bankSpeed[3:1] == 3'b111 |-> rowStrobe[3:1] == 3'b000;
    endproperty
    a_bankOff: assert property (p_bankOff) else $error("disabled row strobe active"); // see (RQ15)
    property p_refPending;
        refreshRequest && !refreshBusy |=> ##[0:2] refreshBusy;
    endproperty
    a_refPending: assert property (p_refPending) else $error("refresh burst not started"); // see (RQ9)
    property p_force;
        st.stbSetup[4:3] == 2'b01 |-> forceMiss && !forceHit;
    endproperty
    a_force: assert property (p_force) else $error("forced miss not shown"); // see (RQ12)
    property p_stdRef;
        refreshRequest && st.l2Ctl[0] |=> !busRefreshPulse;
    endproperty
    a_stdRef: assert property (p_stdRef) else $error("standard refresh not stopped"); // see (RQ6)
    c_turbo: cover property (turboSpeed && !turboPin);
    c_hidden: cover property (refreshBusy && !refreshHoldCpu);
    c_statusRead: cover property (s_axi_arvalid && s_axi_arready && rdIdx == `CDB_IDX_STATUS);
endmodule

// ---- sim/cdb_dram_model.sv ----
// Far-side DRAM model: counts the cycles that bank 0 row strobe and refresh busy are high.
// Assumes the bench keeps the bank 0 request low while a refresh is counted.
`timescale 1ns/1ps
module cdb_dram_model
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic srst,
    // Observed lines.
    input  wire logic rasLine,
    input  wire logic busy,
    // Counts.
    output logic [7:0] strobeCnt,
    output logic [7:0] busyCnt
);
    // One total per line shows width, precharge and burst count together.
    always_ff @(posedge clk_sys)
    begin
        strobeCnt <= srst ? 8'h00 : strobeCnt + {7'h00, rasLine};
        busyCnt   <= srst ? 8'h00 : busyCnt + {7'h00, busy};
    end
endmodule

// ---- sim/cdb_config_regs_tb_top.sv ----
// Bench for the configuration bank: bus reads and writes with expected values.
// Assumes the default version code of 3'h5 and a strap that selects the newer processor.
`timescale 1ns/1ps
module cdb_config_regs_tb_top;
    logic clk_sys, srst, cpuNewGen, l2WriteBack, turboPin, refreshRequest, dmaReqIn;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr, strobeCnt, busyCnt, strobeBase;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, rowStrobeReq, rowStrobe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic cacheBurstFast, cacheWriteWait, postedWriteWait, forceHit, forceMiss, dmaClkFromCpu;
    logic cpuCacheDisable, cycleStartDelay, busExtraWait, offCycleWait, busRefreshPulse;
    logic refreshBusy, refreshHoldCpu, localBusEnable, turboSpeed, dmaReqDelayed;
    logic [7:0] readMask [5] = '{8'hf3, 8'hf7, 8'hdb, 8'h1f, 8'h0d};
    int miscompares, checked, cycles;
    cdb_config_regs dut_u (.*);
    cdb_dram_model model_u (.clk_sys, .srst, .rasLine(rowStrobe[0]), .busy(refreshBusy),
                            .strobeCnt, .busyCnt);
    always #50 clk_sys = ~clk_sys;
    // A stuck handshake would hang the run, so a cycle ceiling ends it.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            end_sim;
        end
    end
    task chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Address and data are offered together and each is dropped once taken.
    task wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] rsp);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {rsp, 32'h0000_0000}, {s_axi_bresp, 32'h0000_0000});
        @(posedge clk_sys);
    endtask
    task rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] rsp);
        s_axi_araddr <= {idx, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", {rsp, 24'h00_0000, d}, {s_axi_rresp, s_axi_rdata});
        @(posedge clk_sys);
    endtask
    task end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Reset, then registers, pin-driven outputs, a bad address and one refresh burst.
    initial
    begin
        {clk_sys, refreshRequest, dmaReqIn, l2WriteBack, turboPin, srst, cpuNewGen} = 7'h03;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
        {s_axi_wstrb, rowStrobeReq} = 8'hf0;
        {miscompares, checked, cycles} = 96'h0;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd(6'h18, 8'h00, 2'b00);
        rd(6'h1a, 8'h80, 2'b00);
        rd(6'h1c, 8'h05, 2'b00);
        $display("test reset done");
        turboPin <= 1'b1;
        for (int i = 0; i < 5; i++) wr(6'h18 + 6'(i), 8'hff, 2'b00);
        for (int i = 0; i < 5; i++) rd(6'h18 + 6'(i), readMask[i], 2'b00);
        chk("l2", 34'h1d, 34'({cacheBurstFast, busExtraWait, offCycleWait, cacheWriteWait,
            postedWriteWait}));
        l2WriteBack <= 1'b1;
        rowStrobeReq <= 4'hf;
        @(posedge clk_sys);
        chk("wb", 34'h2, 34'({cacheWriteWait, postedWriteWait}));
        chk("stb", 34'h1d, 34'({cycleStartDelay, cpuCacheDisable, forceHit, forceMiss,
            dmaClkFromCpu}));
        chk("bank", 34'h21, 34'({localBusEnable, turboSpeed, rowStrobe}));
        turboPin <= 1'b0;
        @(posedge clk_sys);
        chk("turbo", 34'h1, 34'(turboSpeed));
        wr(6'h1a, 8'h08, 2'b00);
        chk("miss", 34'h1, 34'({forceHit, forceMiss}));
        dmaReqIn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("dma2", 34'h0, 34'(dmaReqDelayed));
        @(posedge clk_sys);
        chk("dma3", 34'h1, 34'(dmaReqDelayed));
        rd(6'h1d, 8'h00, 2'b10);
        wr(6'h1d, 8'h55, 2'b10);
        $display("test registers done");
        rowStrobeReq <= 4'h0;
        wr(6'h18, 8'h00, 2'b00);
        wr(6'h19, 8'hd1, 2'b00);
        strobeBase = strobeCnt;
        refreshRequest <= 1'b1;
        @(posedge clk_sys);
        refreshRequest <= 1'b0;
        @(posedge clk_sys);
        chk("std", 34'h2, 34'({busRefreshPulse, refreshHoldCpu}));
        @(posedge clk_sys);
        chk("hold", 34'h1, 34'({busRefreshPulse, refreshHoldCpu}));
        repeat (20) @(posedge clk_sys);
        chk("strobe", 34'h4, 34'(strobeCnt - strobeBase));
        chk("busy", 34'ha, 34'(busyCnt));
        $display("test refresh done");
        end_sim;
    end
endmodule
